// ==== hdl/lbg_cfg.svh ====
// Constants of the LED brightness and group PWM block
// Assumes a 40 MHz system clock and an 8-bit register port
//
// Contract
// RQ1 - Each channel's individual PWM repeats at a fixed 97 kHz.
// RQ2 - Individual high fraction is duty/256; 00h is off, FFh is 99.6 percent.
// RQ3 - Individual duty acts only when the channel selector is 10 or 11.
// RQ4 - Dimming mode ANDs a 190 Hz group PWM into qualifying channels.
// RQ5 - Group high fraction is group duty/256 in 256 linear steps.
// RQ6 - Group dimming or blinking affects only channels with selector 11.
// RQ7 - Blink mode: period register sets period, group duty sets on ratio.
// RQ8 - Blink period is (period value + 1) / 24 seconds.
// RQ9 - In dimming mode the period register has no effect.
// RQ10 - Selector 00 holds the channel off; selectors reset to 00.
// RQ11 - Selector 01 holds the channel fully on, ignoring all duty settings.
// RQ12 - Selector 10 uses the individual duty only, no group effect.
// RQ13 - Selector 11 uses individual duty plus group dimming or blinking.
// RQ14 - Selectors pack four per byte, channel n at bits 2(n mod 4)+1:2(n mod 4).
// RQ15 - Group mode select is bit 5 of mode register two; 0 dims, 1 blinks.
// RQ16 - Duty, group and state writes apply at stop, or at ack when selected.
// RQ17 - No dimming or blinking activity while the oscillator is off.
// RQ18 - Selector 11 output is individual pulse AND group pulse or blink.
`ifndef LBG_CFG_SVH
`define LBG_CFG_SVH

// ----------------------------------------------------------------
// Register offsets and indices
// ----------------------------------------------------------------
`define LBG_ADDR_MODE1  5'h00
`define LBG_ADDR_SECOND_MODE_REGISTER  5'h01
`define LBG_ADDR_DUTY0  5'h02
`define LBG_ADDR_STHI   5'h0D
`define LBG_NREG        12
`define LBG_IDX_GDUTY   4'h8
`define LBG_IDX_GPER    4'h9
`define LBG_IDX_STLO    4'hA
`define LBG_IDX_STHI    4'hB

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define LBG_OSC_BIT     4
`define LBG_BLINK_BIT   5
`define LBG_UPDACK_BIT  3
`define LBG_GDUTY_RST   8'hFF
`define LBG_DUTY_RST    8'h00
`define LBG_OSCOFF_RST  1'b1
`define LBG_SEL_OFF     2'b00
`define LBG_SEL_ON      2'b01
`define LBG_SEL_IND     2'b10
`define LBG_SEL_GRP     2'b11

// ----------------------------------------------------------------
// Clock and PWM rates
// ----------------------------------------------------------------
`define LBG_CLK_HZ      40000000
`define LBG_FAST_HZ     97000
`define LBG_DIM_HZ      190
`define LBG_BLINK_DIV   24
`define LBG_STEPS       256

`endif

// ==== hdl/lbg_group_gen.sv ====
// Group controller: 190 Hz dimming PWM or slow programmable blink
// Assumes period and duty come from applied registers, same clock
`timescale 1ns/1ps
`include "lbg_cfg.svh"
module lbg_group_gen
  import lbg_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // Controls
  input  wire logic       run,
  input  lbg_gmode_e      gMode,
  input  wire lbg_byte_t  period,
  input  wire lbg_byte_t  duty,
  // Group pulse
  output logic            grpOn
);
  logic      dimTick;
  logic      baseTick;
  logic      step;
  lbg_byte_t pre_r;
  lbg_byte_t grpCnt_r;

  // Step sources: 190 Hz x 256 and 24 Hz x 256
  lbg_rate_tick #(.INC(`LBG_DIM_HZ * `LBG_STEPS), .MOD(`LBG_CLK_HZ))
    uDim (.clk_sys(clk_sys), .sys_rst(sys_rst), .run(run),
          .tick(dimTick));
  lbg_rate_tick #(.INC(`LBG_BLINK_DIV * `LBG_STEPS), .MOD(`LBG_CLK_HZ))
    uBase (.clk_sys(clk_sys), .sys_rst(sys_rst), .run(run),
           .tick(baseTick));

  // Blink divides base ticks by period + 1
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pre_r <= 8'h00;
    end else if (gMode == LBG_BLINK && baseTick) begin // RQ8
      pre_r <= (pre_r >= period) ? 8'h00 : pre_r + 8'h01;
    end
  end

  // Period ignored when dimming
  assign step = (gMode == LBG_BLINK) ?                   // RQ7
                (baseTick && pre_r >= period) : dimTick; // RQ9 RQ4

  // Group phase counter
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      grpCnt_r <= 8'h00;
    end else if (step) begin
      grpCnt_r <= grpCnt_r + 8'h01;
    end
  end

  // High for duty of 256 steps
  assign grpOn = grpCnt_r < duty; // RQ5

  property p_grp_zero;
    @(posedge clk_sys) disable iff (sys_rst)
    duty == 8'h00 |-> !grpOn;
  endproperty
  a_grp_zero: assert property (p_grp_zero) // RQ5
    else $error("group pulse high with zero duty");

  property p_dim_step;
    @(posedge clk_sys) disable iff (sys_rst)
    gMode == LBG_DIM && !dimTick |=> $stable(grpCnt_r);
  endproperty
  a_dim_step: assert property (p_dim_step) // RQ9
    else $error("dimming counter moved without dim tick");

  property p_blink_wrap;
    @(posedge clk_sys) disable iff (sys_rst)
    gMode == LBG_BLINK && baseTick && pre_r == period
      |=> pre_r == 8'h00 && grpCnt_r == $past(grpCnt_r) + 8'h01;
  endproperty
  a_blink_wrap: assert property (p_blink_wrap) // RQ8
    else $error("blink prescaler did not wrap at period");
endmodule

// ==== hdl/lbg_led_pwm.sv ====
// Eight-channel LED PWM with individual and group brightness control
// Assumes a serial front end on the same clock driving the register
// port and one-cycle acknowledge and stop pulses
`timescale 1ns/1ps
`include "lbg_cfg.svh"
module lbg_led_pwm
  import lbg_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // Register port from the serial front end
  input  wire logic       regWrEn,
  input  wire logic [4:0] regAddr,
  input  wire lbg_byte_t  regWrData,
  output lbg_byte_t       regRdData,
  // Serial bus framing events
  input  wire logic       busAck,
  input  wire logic       busStop,
  // LED drive, high turns the sink on
  output logic [7:0]      ledDrv
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  lbg_byte_t  stage_r  [`LBG_NREG];
  lbg_byte_t  live_r   [`LBG_NREG];
  lbg_byte_t  stageNxt [`LBG_NREG];
  logic       oscOff_r;
  lbg_gmode_e gMode_r;
  logic       updOnAck_r;
  logic       applyNow;
  logic       fastTick;
  lbg_byte_t  fastCnt_r;
  logic       grpOn;
  logic [7:0] drvNxt;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Address falls on a staged register
  function automatic logic inMap(input logic [4:0] a);
    inMap = (a >= `LBG_ADDR_DUTY0) && (a <= `LBG_ADDR_STHI);
  endfunction

  // Staged register index of an address
  function automatic logic [3:0] regIdx(input logic [4:0] a);
    regIdx = 4'(a - `LBG_ADDR_DUTY0);
  endfunction

  // Power-up value of a staged register
  function automatic lbg_byte_t rstVal(input int i);
    rstVal = (4'(i) == `LBG_IDX_GDUTY) ? `LBG_GDUTY_RST : `LBG_DUTY_RST;
  endfunction

  // Selector of channel n from the applied state bytes
  function automatic lbg_sel_t selOf(input int n);
    lbg_byte_t b;
    b = (n < 4) ? live_r[`LBG_IDX_STLO] : live_r[`LBG_IDX_STHI];
    selOf = b[2 * (n % 4) +: 2]; // RQ14
  endfunction

  // Pulse high while the phase is below the duty
  function automatic logic pwmHigh(input lbg_byte_t cnt,
                                   input lbg_byte_t duty);
    pwmHigh = cnt < duty; // RQ2
  endfunction

  // Drive level from selector and the two pulses
  function automatic logic chanDrive(input lbg_sel_t sel,
                                     input logic ind,
                                     input logic grp);
    case (sel)
      `LBG_SEL_OFF: chanDrive = 1'b0;     // RQ10
      `LBG_SEL_ON:  chanDrive = 1'b1;     // RQ11
      `LBG_SEL_IND: chanDrive = ind;      // RQ12 RQ3
      `LBG_SEL_GRP: chanDrive = ind & grp; // RQ13 RQ18 RQ6
      default:      chanDrive = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Mode registers
  // ----------------------------------------------------------------

  // Oscillator, group mode and update timing bits, immediate
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      oscOff_r   <= `LBG_OSCOFF_RST;
      gMode_r    <= LBG_DIM;
      updOnAck_r <= 1'b0;
    end else if (regWrEn && regAddr == `LBG_ADDR_MODE1) begin
      oscOff_r <= regWrData[`LBG_OSC_BIT];
    end else if (regWrEn && regAddr == `LBG_ADDR_SECOND_MODE_REGISTER) begin
      gMode_r    <= regWrData[`LBG_BLINK_BIT] ? LBG_BLINK : LBG_DIM; // RQ15
      updOnAck_r <= regWrData[`LBG_UPDACK_BIT]; // RQ16
    end
  end

  // ----------------------------------------------------------------
  // Staged and applied registers
  // ----------------------------------------------------------------

  // Merge the current write into the staged copy
  always_comb begin
    for (int i = 0; i < `LBG_NREG; i++) begin
      stageNxt[i] = stage_r[i];
      if (regWrEn && inMap(regAddr) && regIdx(regAddr) == 4'(i)) begin
        stageNxt[i] = regWrData;
      end
    end
  end

  // Staged copy follows every write
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < `LBG_NREG; i++) begin
        stage_r[i] <= rstVal(i);
      end
    end else begin
      for (int i = 0; i < `LBG_NREG; i++) begin
        stage_r[i] <= stageNxt[i];
      end
    end
  end

  // Apply point: stop by default, acknowledge when selected
  assign applyNow = updOnAck_r ? busAck : busStop; // RQ16

  // Applied copy drives the outputs
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < `LBG_NREG; i++) begin
        live_r[i] <= rstVal(i);
      end
    end else if (applyNow) begin
      for (int i = 0; i < `LBG_NREG; i++) begin
        live_r[i] <= stageNxt[i]; // RQ16
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // Registered read of the addressed byte, reserved bits zero
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      regRdData <= 8'h00;
    end else begin
      case (regAddr)
        `LBG_ADDR_MODE1: begin
          regRdData <= {3'h0, oscOff_r, 4'h0};
        end
        `LBG_ADDR_SECOND_MODE_REGISTER: begin
          regRdData <= {2'h0, gMode_r == LBG_BLINK, 1'b0,
                        updOnAck_r, 3'h0};
        end
        default: begin
          regRdData <= inMap(regAddr) ? stage_r[regIdx(regAddr)] : 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Individual fast PWM
  // ----------------------------------------------------------------

  // Tick at 97 kHz times 256 steps
  lbg_rate_tick #(.INC(`LBG_FAST_HZ * `LBG_STEPS), .MOD(`LBG_CLK_HZ))
    uFast (.clk_sys(clk_sys), .sys_rst(sys_rst), .run(!oscOff_r),
           .tick(fastTick)); // RQ1 RQ17

  // Shared phase counter for all channels
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fastCnt_r <= 8'h00;
    end else if (fastTick) begin
      fastCnt_r <= fastCnt_r + 8'h01; // RQ1
    end
  end

  // ----------------------------------------------------------------
  // Group controller
  // ----------------------------------------------------------------

  // Dimming or blinking from the applied group registers
  lbg_group_gen uGroup (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .run     (!oscOff_r), // RQ17
    .gMode   (gMode_r),
    .period  (live_r[`LBG_IDX_GPER]),
    .duty    (live_r[`LBG_IDX_GDUTY]),
    .grpOn   (grpOn)
  );

  // ----------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------

  // Per-channel level, pulses blocked while oscillator is off
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      drvNxt[i] = chanDrive(selOf(i),
                            !oscOff_r && pwmHigh(fastCnt_r, live_r[i]),
                            !oscOff_r && grpOn); // RQ17
    end
  end

  // Registered drive
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ledDrv <= 8'h00;
    end else begin
      ledDrv <= drvNxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  property p_fast_rate;
    @(posedge clk_sys) disable iff (sys_rst)
    (!oscOff_r) [*3] ##0 !fastTick |-> $past(fastTick);
  endproperty
  a_fast_rate: assert property (p_fast_rate) // RQ1
    else $error("fast tick gap longer than two cycles");

  // Selectors sliced directly so the check sees sampled, not updated, state
  property p_duty_zero;
    @(posedge clk_sys) disable iff (sys_rst)
    live_r[`LBG_IDX_STLO][1:0] == `LBG_SEL_IND && live_r[0] == 8'h00
      |=> !ledDrv[0];
  endproperty
  a_duty_zero: assert property (p_duty_zero) // RQ2
    else $error("channel 0 on with zero duty");

  property p_ind_only;
    @(posedge clk_sys) disable iff (sys_rst)
    live_r[`LBG_IDX_STLO][3:2] == `LBG_SEL_IND
      |=> ledDrv[1] == ($past(fastCnt_r) < $past(live_r[1])
                        && !$past(oscOff_r));
  endproperty
  a_ind_only: assert property (p_ind_only) // RQ12
    else $error("channel 1 in individual mode mismatched");

  property p_off;
    @(posedge clk_sys) disable iff (sys_rst)
    live_r[`LBG_IDX_STLO][5:4] == `LBG_SEL_OFF |=> !ledDrv[2];
  endproperty
  a_off: assert property (p_off) // RQ10
    else $error("channel 2 on while selector is off");

  property p_full_on;
    @(posedge clk_sys) disable iff (sys_rst)
    live_r[`LBG_IDX_STHI][3:2] == `LBG_SEL_ON |=> ledDrv[5];
  endproperty
  a_full_on: assert property (p_full_on) // RQ11
    else $error("channel 5 not on while selector is on");

  property p_group_and;
    @(posedge clk_sys) disable iff (sys_rst)
    live_r[`LBG_IDX_STHI][7:6] == `LBG_SEL_GRP && !oscOff_r
      |=> ledDrv[7] == ($past(fastCnt_r) < $past(live_r[7])
                        && $past(grpOn));
  endproperty
  a_group_and: assert property (p_group_and) // RQ18
    else $error("channel 7 not the AND of both pulses");

  property p_hold;
    @(posedge clk_sys) disable iff (sys_rst)
    !applyNow |=> live_r[0] == $past(live_r[0])
                  && live_r[`LBG_IDX_STHI] == $past(live_r[`LBG_IDX_STHI]);
  endproperty
  a_hold: assert property (p_hold) // RQ16
    else $error("applied register changed without apply point");

  property p_stop_apply;
    @(posedge clk_sys) disable iff (sys_rst)
    busStop && !updOnAck_r ##1 !busStop [*2]
      |-> live_r[`LBG_IDX_GDUTY] == $past(stage_r[`LBG_IDX_GDUTY]);
  endproperty
  a_stop_apply: assert property (p_stop_apply) // RQ16
    else $error("group duty not applied at stop");

  property p_osc_freeze;
    @(posedge clk_sys) disable iff (sys_rst)
    oscOff_r && $past(oscOff_r) |=> $stable(fastCnt_r); // Last tick drains
  endproperty
  a_osc_freeze: assert property (p_osc_freeze) // RQ17
    else $error("fast counter ran with oscillator off");

  property p_mode_bit;
    @(posedge clk_sys) disable iff (sys_rst)
    regWrEn && regAddr == `LBG_ADDR_SECOND_MODE_REGISTER
      |=> (gMode_r == LBG_BLINK) == $past(regWrData[`LBG_BLINK_BIT]);
  endproperty
  a_mode_bit: assert property (p_mode_bit) // RQ15
    else $error("group mode not taken from bit 5");

endmodule

// ==== hdl/lbg_pkg.sv ====
// Types shared by the LED brightness and group PWM block
// Assumes the constants header for numeric values
package lbg_pkg;
  typedef logic [7:0] lbg_byte_t;
  typedef logic [1:0] lbg_sel_t;
  typedef enum logic {LBG_DIM, LBG_BLINK} lbg_gmode_e;
endpackage

// ==== hdl/lbg_rate_tick.sv ====
// Fractional rate generator, one-cycle tick at INC/MOD of the clock
// Assumes INC below MOD and both below 2**26
`timescale 1ns/1ps
module lbg_rate_tick #(
  parameter int unsigned INC = 1,
  parameter int unsigned MOD = 2
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Run enable and tick out
  input  wire logic run,
  output logic      tick
);
  localparam int AW = 27;
  logic [AW-1:0] acc_r;
  logic [AW-1:0] sum;

  // Phase accumulator step
  assign sum = acc_r + AW'(INC);

  // Accumulate while running, tick on wrap
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      acc_r <= '0;
      tick  <= 1'b0;
    end else if (!run) begin
      tick <= 1'b0;
    end else if (sum >= AW'(MOD)) begin
      acc_r <= sum - AW'(MOD);
      tick  <= 1'b1;
    end else begin
      acc_r <= sum;
      tick  <= 1'b0;
    end
  end
endmodule

// ==== test/lbg_host_model.sv ====
// Host model: serial front end seen as register writes and framing pulses
// Assumes the block samples its inputs on the rising edge of clk_sys
`timescale 1ns/1ps
module lbg_host_model
  import lbg_pkg::*;
(
  // Clock
  input  wire logic       clk_sys,
  // Register port toward the block
  output logic            regWrEn,
  output logic [4:0]      regAddr,
  output lbg_byte_t       regWrData,
  input  wire lbg_byte_t  regRdData,
  // Framing pulses
  output logic            busAck,
  output logic            busStop
);
  localparam time SKEW = 2ns;

  // Idle bus at time zero
  initial begin
    regWrEn   = 1'b0;
    regAddr   = 5'h1F;
    regWrData = 8'h00;
    busAck    = 1'b0;
    busStop   = 1'b0;
  end

  // One byte write, strobe held for exactly one edge
  task automatic wr(input logic [4:0] a, input lbg_byte_t d);
    @(posedge clk_sys);
    #SKEW;
    regAddr   = a;
    regWrData = d;
    regWrEn   = 1'b1;
    @(posedge clk_sys);
    #SKEW;
    regWrEn   = 1'b0;
    regWrData = ~d;    // Stale data no longer means anything
  endtask

  // Read: address held, registered answer one edge later
  task automatic rd(input logic [4:0] a, output lbg_byte_t d);
    @(posedge clk_sys);
    #SKEW;
    regAddr = a;
    @(posedge clk_sys);
    #SKEW;
    d = regRdData;
  endtask

  // One-cycle acknowledge or stop event
  task automatic pulse(input logic useAck);
    @(posedge clk_sys);
    #SKEW;
    busAck  = useAck;
    busStop = ~useAck;
    @(posedge clk_sys);
    #SKEW;
    busAck  = 1'b0;
    busStop = 1'b0;
  endtask
endmodule

// ==== test/led_brightness_group_pwm_tb.sv ====
// Self-checking bench for the eight-channel LED PWM block
// Assumes the host model drives the register port and framing pulses
`timescale 1ns/1ps
module led_brightness_group_pwm_tb
  import lbg_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and bench state
  // ----------------------------------------------------------------
  localparam int W   = 4124;   // About ten fast PWM periods
  localparam int TOL = 40;     // Tick jitter and window phase
  localparam logic [7:0] RST_VAL [16] = '{8'h10, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00};
  logic        clk_sys;
  logic        sys_rst;
  logic        regWrEn;
  logic [4:0]  regAddr;
  lbg_byte_t   regWrData;
  lbg_byte_t   regRdData;
  logic        busAck;
  logic        busStop;
  logic [7:0]  ledDrv;
  int          errTotal = 0;
  int          checks = 0;
  int          hiCnt [8];
  int          viol;
  logic [31:0] rng = 32'h455E132A;
  lbg_byte_t   rv;
  lbg_byte_t   duty [8];
  logic [15:0] st;
  logic        ack;
  logic        blink;

  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  lbg_led_pwm lbg_led_pwm_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .regWrEn(regWrEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .busAck(busAck), .busStop(busStop), .ledDrv(ledDrv));
  lbg_host_model lbg_host_model_i (
    .clk_sys(clk_sys), .regWrEn(regWrEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .busAck(busAck),
    .busStop(busStop));

  // 40 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  // Expected high cycles per window, group duty held at zero
  function automatic int expHi(input lbg_sel_t s, input lbg_byte_t d);
    case (s)
      2'b00:   return 0;
      2'b01:   return W;
      2'b10:   return int'(d) * W / 256;
      default: return 0;
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input int tol);
    checks++;
    if (^seen === 1'bx || seen + tol < exp || seen > exp + tol) begin
      errTotal++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input lbg_byte_t d);
    lbg_host_model_i.wr(a, d);
  endtask

  task automatic rd(input logic [4:0] a, output lbg_byte_t d);
    lbg_host_model_i.rd(a, d);
  endtask

  task automatic pulse(input logic useAck);
    lbg_host_model_i.pulse(useAck);
  endtask

  // Let edges pass, then step off the edge
  task automatic waitCyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Count high cycles per channel, and channel 1 high without channel 0
  task automatic measure();
    hiCnt = '{default: 0};
    viol = 0;
    repeat (W) begin
      @(posedge clk_sys);
      #1;
      for (int c = 0; c < 8; c++)
        if (ledDrv[c] === 1'b1) hiCnt[c]++;
      if (ledDrv[1] === 1'b1 && ledDrv[0] !== 1'b1) viol++;
    end
  endtask

  task automatic wrapUp();
    $display("checks=%0d mismatches=%0d", checks, errTotal);
    if (errTotal == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    errTotal++;
    wrapUp();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #2;
    sys_rst = 1'b0;
    // Reset values and an unmapped write
    check(ledDrv, 8'h00, 0);
    for (int i = 0; i < 16; i++) begin
      rd(i[4:0], rv);
      check(rv, RST_VAL[i], 0);
    end
    wr(5'h1F, 8'hFF);
    rd(5'h1F, rv);
    check(rv, 8'h00, 0);
    // Staged states: acknowledge ignored by default, stop applies
    wr(5'h0C, 8'h55);
    rd(5'h0C, rv);
    check(rv, 8'h55, 0);
    pulse(1'b1);
    waitCyc(3);
    check(ledDrv, 8'h00, 0);
    pulse(1'b0);
    waitCyc(3);
    check(ledDrv, 8'h0F, 0);
    wr(5'h00, 8'h00);
    // Random selectors, duties and modes with group duty zero
    for (int r = 0; r < 10; r++) begin
      rng = lfsr(rng);
      ack = rng[0];
      blink = rng[1] | (r >= 6);   // Long blink run reaches the wrap
      st = (r == 0) ? 16'hE4E4 : (r == 1) ? 16'hAAAA : rng[31:16];
      wr(5'h01, {2'b00, blink, 1'b0, ack, 3'b000});
      for (int c = 0; c < 8; c++) begin
        rng = lfsr(rng);
        duty[c] = (r >= 2) ? rng[7:0] : (c[1] ^ r[0]) ? 8'hFF : 8'h00;
        wr(5'h02 + c[4:0], duty[c]);
      end
      wr(5'h0A, 8'h00);
      wr(5'h0B, (r >= 6) ? 8'h00 : rng[15:8]);
      wr(5'h0C, st[7:0]);
      wr(5'h0D, st[15:8]);
      pulse(ack);
      waitCyc(3);
      measure();
      for (int c = 0; c < 8; c++)
        check(hiCnt[c], expHi(st[2*c +: 2], duty[c]), TOL);
    end
    // Group dimming near full: channel 1 gated by the group pulse
    wr(5'h01, 8'h00);
    wr(5'h02, 8'h80);
    wr(5'h03, 8'h80);
    wr(5'h0A, 8'hFF);
    wr(5'h0C, 8'h0E);
    wr(5'h0D, 8'h00);
    pulse(1'b0);
    waitCyc(3);
    measure();
    check(viol, 0, 0);
    check(hiCnt[1] > 0, 1, 0);
    check(hiCnt[0], expHi(2'b10, 8'h80), TOL);
    // Oscillator off: only fully-on channels drive
    wr(5'h0C, 8'h1E);
    pulse(1'b0);
    wr(5'h00, 8'h10);
    waitCyc(3);
    measure();
    check(hiCnt[0], 0, 0);
    check(hiCnt[1], 0, 0);
    check(hiCnt[2], W, 0);
    wrapUp();
  end
endmodule
